/* rtl/svd_pkg.sv */
/*
  constants for the supply voltage detector control block: register
  offsets, field positions, reset values and timing counts.
  assumes a 250 mhz system clock and an 8-bit register port.
*/
package svd_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] detector_control_off    = 4'h0;
  localparam logic [3:0] trip_level_register_off = 4'h1;
  localparam logic [3:0] event_status_off        = 4'h2;
  // ****************************************
  // field positions
  // ****************************************
  localparam int enable_bit       = 7;
  localparam int compare_bit      = 5;
  localparam int ready_bit        = 4;
  localparam int rising_bit       = 1;
  localparam int falling_bit      = 0;
  localparam int event_bit        = 0;
  localparam int level_w          = 4;
  localparam logic [3:0] level_reserved = 4'hf;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] control_rst = 8'h00;
  localparam logic [3:0] level_rst   = 4'h0;
  // ****************************************
  // timing
  // ****************************************
  localparam int clk_mhz        = 250;
  localparam int settle_ns      = 20;
  localparam int settle_cycles  = (settle_ns * clk_mhz) / 1000;
  localparam int settle_w       = 8;
endpackage

/* rtl/svd_sync.sv */
/*
  two-flip-flop synchroniser for the analog comparator and reference
  levels. assumes inputs are asynchronous levels and clk is free running.
*/
module svd_sync (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_ff;
  // ****************************************
  // first stage read only by second stage
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_ff  <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule // svd_sync

/* rtl/supply_voltage_detect_ctrl.sv */
/*
  control and status logic for the supply voltage detector.
  assumes the analog comparator, divider and reference sit outside and
  drive asynchronous levels; por marks power-on reset apart from srst.
*/
module supply_voltage_detect_ctrl
  import svd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        por,
  input  wire logic [3:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  input  wire logic        cmp_low,
  input  wire logic        ref_stable,
  input  wire logic        freeze,
  input  wire logic        sleep,
  output logic             detector_power,
  output logic      [3:0]  level_sel,
  output logic             detect_event_flag,
  output logic             wake
);
  import svd_pkg::*;

  logic       enable_ff;
  logic       rising_ff;
  logic       falling_ff;
  logic [3:0] level_ff;
  logic       ready_ff;
  logic       event_ff;
  logic       cmp_prev_ff;
  logic [settle_w-1:0] settle_ff;
  logic       cmp_s;
  logic       ref_s;
  logic       rise_hit;
  logic       fall_hit;
  logic       nxt_event;

  // ****************************************
  // input synchronisers
  // ****************************************
  svd_sync u_cmp (
    .clk      (clk),
    .srst     (srst),
    .async_in (cmp_low),
    .sync_out (cmp_s)
  );
  svd_sync u_ref (
    .clk      (clk),
    .srst     (srst),
    .async_in (ref_stable),
    .sync_out (ref_s)
  );

  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      enable_ff  <= control_rst[enable_bit];
      rising_ff  <= control_rst[rising_bit];
      falling_ff <= control_rst[falling_bit];
    end else if (wr && addr == detector_control_off) begin
      enable_ff  <= wdata[enable_bit];
      rising_ff  <= wdata[rising_bit];
      falling_ff <= wdata[falling_bit];
    end
  end

  // ****************************************
  // trip level register
  // ****************************************
  always_ff @(posedge clk) begin
    if (por) begin
      level_ff <= level_rst;
    end else if (wr && addr == trip_level_register_off) begin
      level_ff <= wdata[level_w-1:0];
    end
  end

  // ****************************************
  // readiness
  // ****************************************
  // settle count guards against a reference that reports stable too early
  always_ff @(posedge clk) begin
    if (srst || !enable_ff) begin
      settle_ff <= '0;
      ready_ff  <= 1'b0;
    end else if (freeze) begin
      ready_ff <= ready_ff;
    end else if (!ref_s) begin
      settle_ff <= '0;
      ready_ff  <= 1'b0;
    end else if (settle_ff < settle_w'(settle_cycles)) begin
      settle_ff <= settle_ff + 1'b1;
    end else begin
      ready_ff <= 1'b1;
    end
  end

  // ****************************************
  // crossing detection
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      cmp_prev_ff <= 1'b0;
    end else begin
      cmp_prev_ff <= cmp_s;
    end
  end

  assign rise_hit = rising_ff && cmp_prev_ff && !cmp_s;
  assign fall_hit = falling_ff && !cmp_prev_ff && cmp_s;

  always_comb begin
    nxt_event = event_ff;
    if (wr && addr == event_status_off && !wdata[event_bit]) begin
      nxt_event = 1'b0;
    end
    if (enable_ff && ready_ff && !freeze && (rise_hit || fall_hit)) begin
      nxt_event = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      event_ff <= 1'b0;
    end else begin
      event_ff <= nxt_event;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      detector_power    <= 1'b0;
      level_sel         <= level_rst;
      detect_event_flag <= 1'b0;
      wake              <= 1'b0;
    end else begin
      detector_power    <= enable_ff;
      level_sel         <= level_ff;
      detect_event_flag <= nxt_event;
      wake              <= sleep && nxt_event && !event_ff;
    end
  end

  // ****************************************
  // read port
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= 8'h00;
      if (addr == detector_control_off) begin
        rdata[enable_bit]  <= enable_ff;
        rdata[compare_bit] <= cmp_s && enable_ff;
        rdata[ready_bit]   <= ready_ff;
        rdata[rising_bit]  <= rising_ff;
        rdata[falling_bit] <= falling_ff;
      end else if (addr == trip_level_register_off) begin
        rdata[level_w-1:0] <= level_ff;
      end else if (addr == event_status_off) begin
        rdata[event_bit] <= event_ff;
      end
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule // supply_voltage_detect_ctrl

/* testbench/svd_analog.sv */
/*
  behavioural model of the analog comparator and reference.
  assumes supply and limit are compared as 4-bit level codes.
*/
module svd_analog (
  input  wire logic       clk,
  input  wire logic       detector_power,
  input  wire logic [3:0] level_sel,
  input  wire logic [3:0] supply,
  input  wire logic [6:0] ramp,
  output logic            cmp_low,
  output logic            ref_stable
);
  logic [6:0] cnt_ff;
  logic       cmp_ff = 1'b0;
  // reference needs ramp cycles after power up
  always_ff @(posedge clk) begin
    cnt_ff <= (detector_power === 1'b1) ? cnt_ff + 7'(cnt_ff != ramp) : 7'h0;
  end
  // unpowered comparator output is meaningless, so it toggles
  always_ff @(posedge clk) begin
    cmp_ff <= (detector_power === 1'b1) ? (supply <= level_sel) : !cmp_ff;
  end
  assign cmp_low    = cmp_ff;
  assign ref_stable = detector_power && (cnt_ff == ramp);
endmodule // svd_analog

/* testbench/svd_chk.sv */
/*
  port checker for the supply voltage detector control.
  assumes one clock domain and synchronous srst.
*/
module svd_chk (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       freeze,
  input wire logic       detector_power,
  input wire logic [3:0] level_sel,
  input wire logic       detect_event_flag,
  input wire logic       wake
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  chk_power_follow: assert property (wr && addr == 4'h0 |=> ##1
    detector_power == $past(wdata[7], 2)) else $error("power not enable bit");
  chk_read_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero");
  chk_ctl_zero: assert property (rd && addr == 4'h0 |=> (rdata & 8'h4c) == 8'h00)
    else $error("control spare bits set");
  chk_level_high: assert property (rd && addr == 4'h1 |=> rdata[7:4] == 4'h0)
    else $error("level upper bits set");
  chk_level_copy: assert property (wr && addr == 4'h1 |=> ##1
    level_sel == $past(wdata[3:0], 2)) else $error("level not stored");
  chk_flag_sticky: assert property (detect_event_flag &&
    !(wr && addr == 4'h2 && !wdata[0]) |=> detect_event_flag) else $error("flag lost");
  chk_flag_power: assert property ($rose(detect_event_flag) |-> $past(detector_power))
    else $error("event while off");
  chk_freeze_block: assert property (freeze && !detect_event_flag |=> !detect_event_flag)
    else $error("event in freeze");
  chk_wake_pulse: assert property (wake |-> detect_event_flag ##1 !wake)
    else $error("bad wake pulse");
  cover property ($rose(detect_event_flag));
  cover property (wake);
  cover property (freeze && detector_power);
endmodule // svd_chk
bind supply_voltage_detect_ctrl svd_chk chk_i (.clk, .srst, .addr, .wdata, .wr, .rd,
  .rdata, .freeze, .detector_power, .level_sel, .detect_event_flag, .wake);

/* testbench/supply_voltage_detect_ctrl_tb.sv */
/*
  self-checking bench for the supply voltage detector control.
  assumes the analog side is the svd_analog model.
*/
module supply_voltage_detect_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       srst, por, wr, rd, freeze, sleep, cmp_low, ref_stable;
  logic       detector_power, detect_event_flag, wake;
  logic [3:0] addr, level_sel, supply;
  logic [7:0] wdata, rdata, d;
  logic [6:0] ramp;
  int         n_fail, tests_run, cyc, n_wake;
  supply_voltage_detect_ctrl DUT (.clk, .srst, .por, .addr, .wdata, .wr, .rd, .rdata,
    .cmp_low, .ref_stable, .freeze, .sleep, .detector_power, .level_sel,
    .detect_event_flag, .wake);
  svd_analog far_i (.clk, .detector_power, .level_sel, .supply, .ramp, .cmp_low,
    .ref_stable);
  always #2 clk = !clk;
  always @(posedge clk) begin
    cyc++;
    n_wake += int'(wake === 1'b1);
    if (cyc == 20000) begin
      n_fail++;
      test_done;
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic t_regs;
    wr_reg(4'h0, 8'hff); rd_reg(4'h0); chk(d & 8'hcf, 8'h83);
    chk(8'(detector_power), 8'h01);
    wr_reg(4'h1, 8'hff); rd_reg(4'h1); chk(d, 8'h0f);
    chk(8'(level_sel), 8'h0f);
    wr_reg(4'h3, 8'hff); rd_reg(4'h3); chk(d, 8'h00);
    wr_reg(4'h0, 8'h00); wr_reg(4'h1, 8'h05);
    chk(8'(detector_power), 8'h00);
  endtask
  task automatic t_cross(input logic [7:0] c, input logic [3:0] a, input logic [3:0] b,
                         input logic fz, input logic sl, input logic e, input logic e2);
    supply <= a; sleep <= sl;
    wr_reg(4'h0, c);
    repeat (20) @(posedge clk);
    wr_reg(4'h2, 8'h00);
    freeze <= fz; supply <= b;
    repeat (20) @(posedge clk);
    chk(8'(detect_event_flag), 8'(e));
    rd_reg(4'h0); chk(d & 8'h20, {2'b0, b <= 4'h5, 5'h00});
    chk(d & 8'h10, {3'b0, ramp < 7'd20, 4'h0});
    rd_reg(4'h2); chk(d, {7'h00, e});
    @(posedge clk);
    supply <= a;
    repeat (20) @(posedge clk);
    chk(8'(detect_event_flag), 8'(e2));
    wr_reg(4'h2, 8'h01); rd_reg(4'h2); chk(d, {7'h00, e2});
    freeze <= 1'b0; sleep <= 1'b0;
    wr_reg(4'h0, 8'h00);
  endtask
  task automatic t_reset;
    wr_reg(4'h1, 8'h07); wr_reg(4'h0, 8'h80);
    srst <= 1'b1; @(posedge clk); srst <= 1'b0;
    rd_reg(4'h1); chk(d, 8'h07);
    rd_reg(4'h0); chk(d & 8'h83, 8'h00);
    chk(8'(detector_power), 8'h00);
    @(posedge clk);
    srst <= 1'b1; por <= 1'b1; @(posedge clk); srst <= 1'b0; por <= 1'b0;
    rd_reg(4'h1); chk(d, 8'h00);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {srst, por} = 2'b11; {wr, rd, freeze, sleep} = 4'h0;
    addr = 4'h0; wdata = 8'h00; supply = 4'h2; ramp = 7'd4;
    repeat (4) @(posedge clk);
    srst <= 1'b0; por <= 1'b0;
    t_regs;
    t_cross(8'h82, 4'h2, 4'h9, 1'b0, 1'b0, 1'b1, 1'b1);
    t_cross(8'h82, 4'h9, 4'h2, 1'b0, 1'b0, 1'b0, 1'b1);
    t_cross(8'h81, 4'h9, 4'h2, 1'b0, 1'b1, 1'b1, 1'b1);
    t_cross(8'h81, 4'h2, 4'h9, 1'b0, 1'b0, 1'b0, 1'b1);
    t_cross(8'h83, 4'h2, 4'h9, 1'b1, 1'b0, 1'b0, 1'b0);
    chk(8'(n_wake), 8'h01);
    ramp <= 7'd60;
    t_cross(8'h83, 4'h9, 4'h2, 1'b0, 1'b0, 1'b0, 1'b0);
    t_reset;
    test_done;
  end
endmodule // supply_voltage_detect_ctrl_tb
